// ---- core/lpwc_top.sv ----
`timescale 1ns/1ps
`default_nettype none

//
// Overview of operation
// - Sleep keeps RAM and register state retained
// - Location zero may be clobbered on wake from sleep
// - Sleep ends on enabled osc/alarm/port/comparator
// - Reset with monitor off: full POR, re-enable
// - Reset pin falling edge always wakes
// - Config bit 4 is reset-pin wake flag
// - Enable bit one enables, zero disables
// - Config bit 7 sleeps, bit 6 suspends
// - Config bit 5 clears all wake flags
// - Config bits 3:0 enables written, flags read
// - Flag bit 0 cap-sense; bits 7:1 zero
// - Flags set on events regardless of enable
// - Enabled flag set blocks entry and osc off
// - Flags read zero two clocks after suspend
// - Wake cause readable from status register
// - Cap-sense event wakes from suspend
// - Suspend gates clock and stops oscillators
module lpwc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        comparator_out,
    input  wire logic        port_match_evt,
    input  wire logic        rtc_alarm_evt,
    input  wire logic        rtc_osc_fail,
    input  wire logic        cap_sense_done,
    input  wire logic        reset_pin_n,
    input  wire logic        reset_request,
    output logic             sleep_active,
    output logic             suspend_active,
    output logic             sysclk_gate,
    output logic             osc_all_off,
    output logic             ram_retain,
    output logic             lp_osc_off,
    output logic             supply_monitor_off,
    output logic             full_por_req,
    output logic             xram_zero_strobe
);
    localparam int NW = lpwc_pkg::NUM_WAKE;
    localparam int NI = lpwc_pkg::NUM_IN;

    logic [NI-1:0]            in_sync;
    logic [NI-1:0]            evt;
    lpwc_pkg::lpwc_state_t    state_reg;
    lpwc_pkg::lpwc_state_t    state_next;
    logic [NW-1:0]            flags_reg;
    logic [NW-1:0]            en_reg;
    logic [NW-1:0]            en_next;
    logic                     pin_flag_reg;
    logic [1:0]               hide_cnt_reg;
    logic [lpwc_pkg::KEEP_W-1:0] keep_cnt_reg;
    logic [5:0]               cause_reg;
    logic                     mon_dis_reg;
    logic [31:0]              prdata_reg;
    logic                     pready_reg;
    logic                     pslverr_reg;
    logic                     sleep_reg;
    logic                     suspend_reg;
    logic                     gate_reg;
    logic                     osc_all_off_reg;
    logic                     retain_reg;
    logic                     lp_osc_off_reg;
    logic                     full_por_reg;
    logic                     xram_reg;
    logic                     setup;
    logic                     wr;
    logic                     wr_cfg;
    logic                     wr_flg;
    logic                     wr_mode;
    logic                     clear_w;
    logic                     hidden;
    logic                     refuse;
    logic                     wake_sleep;
    logic                     wake_suspend;
    logic                     enter_sleep;
    logic                     enter_suspend;
    logic [7:0]               cfg_rd;
    logic [7:0]               flg_rd;

    // Address match on an aligned word at index times four
    function automatic logic addr_hit(input logic [11:0] a,
                                      input logic [7:0]  idx);
        addr_hit = (a == {2'b00, idx, 2'b00});
    endfunction : addr_hit

    // Pins come from outside the clock domain
    lpwc_sync #(
        .WIDTH    (NI)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({reset_request, reset_pin_n, cap_sense_done,
                    rtc_osc_fail, rtc_alarm_evt, port_match_evt,
                    comparator_out}),
        .sync_out (in_sync)
    );

    lpwc_edge #(
        .WIDTH     (NI),
        .FALL_MASK (lpwc_pkg::FALL_MASK)
    ) u_edge (
        .pclk      (pclk),
        .presetn   (presetn),
        .level     (in_sync),
        .pulse     (evt)
    );

    // Bus decode; writes land at the access edge with pready high
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    assign wr_cfg  = wr & addr_hit(paddr, lpwc_pkg::CONFIG_IDX);
    assign wr_flg  = wr & addr_hit(paddr, lpwc_pkg::FLAGS_IDX);
    assign wr_mode = wr & addr_hit(paddr, lpwc_pkg::MODE_IDX);
    assign clear_w = wr_cfg & pwdata[lpwc_pkg::CFG_CLEAR_BIT];

    // Enables 3:0 come from the same write that selects the mode; cap-sense enable comes from a flag register write
    always_comb begin
        en_next = en_reg;
        if (wr_cfg) begin
            en_next[lpwc_pkg::CFG_SRC_MSB:0] =
                pwdata[lpwc_pkg::CFG_SRC_MSB:0];
        end
        if (wr_flg) begin
            en_next[lpwc_pkg::SRC_CAP] = pwdata[lpwc_pkg::FLG_CAP_BIT];
        end
    end

    // Entry blocked while any enabled flag, incoming event or pin flag
    assign refuse = (|(((clear_w ? '0 : flags_reg) | evt[NW-1:0])
                       & en_next))
                  | (pin_flag_reg & ~clear_w)
                  | evt[lpwc_pkg::SRC_RST_PIN];

    assign enter_sleep   = wr_cfg & pwdata[lpwc_pkg::CFG_SLEEP_BIT]
                         & ~refuse;
    assign enter_suspend = wr_cfg & pwdata[lpwc_pkg::CFG_SUSPEND_BIT]
                         & ~pwdata[lpwc_pkg::CFG_SLEEP_BIT] & ~refuse;
    assign wake_sleep    = (|(evt[NW-1:0] & en_reg & lpwc_pkg::SLEEP_MASK))
                         | evt[lpwc_pkg::SRC_RST_PIN];
    assign wake_suspend  = (|(evt[NW-1:0] & en_reg
                              & lpwc_pkg::SUSPEND_MASK))
                         | evt[lpwc_pkg::SRC_RST_PIN];

    // Power mode sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lpwc_pkg::ST_ACTIVE: begin
                if (enter_sleep) begin
                    state_next = lpwc_pkg::ST_SLEEP;
                end else if (enter_suspend) begin
                    state_next = lpwc_pkg::ST_SUSPEND;
                end
            end
            lpwc_pkg::ST_SLEEP: begin
                if (wake_sleep) begin
                    state_next = lpwc_pkg::ST_ACTIVE;
                end
            end
            lpwc_pkg::ST_SUSPEND: begin
                if (wake_suspend) begin
                    state_next = lpwc_pkg::ST_ACTIVE;
                end
            end
            default: state_next = lpwc_pkg::ST_ACTIVE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= lpwc_pkg::ST_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Mode outputs registered from the next state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_reg       <= 1'b0;
            suspend_reg     <= 1'b0;
            gate_reg        <= 1'b0;
            osc_all_off_reg <= 1'b0;
            retain_reg      <= 1'b0;
        end else begin
            sleep_reg       <= state_next == lpwc_pkg::ST_SLEEP;
            suspend_reg     <= state_next == lpwc_pkg::ST_SUSPEND;
            gate_reg        <= state_next != lpwc_pkg::ST_ACTIVE;
            osc_all_off_reg <= state_next != lpwc_pkg::ST_ACTIVE;
            retain_reg      <= state_next == lpwc_pkg::ST_SLEEP;
        end
    end

    // Enables held until rewritten
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= '0;
        end else begin
            en_reg <= en_next;
        end
    end

    // Sticky flags; an event in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg    <= '0;
            pin_flag_reg <= 1'b0;
        end else begin
            flags_reg    <= (clear_w ? '0 : flags_reg)
                          | evt[NW-1:0];
            pin_flag_reg <= (clear_w ? 1'b0 : pin_flag_reg)
                          | evt[lpwc_pkg::SRC_RST_PIN];
        end
    end

    // Flags masked for two clocks after leaving suspend
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hide_cnt_reg <= '0;
        end else if (state_reg == lpwc_pkg::ST_SUSPEND
                     && state_next == lpwc_pkg::ST_ACTIVE) begin
            hide_cnt_reg <= 2'(lpwc_pkg::FLAG_HIDE_CLKS);
        end else if (hide_cnt_reg != '0) begin
            hide_cnt_reg <= hide_cnt_reg - 2'd1;
        end
    end

    assign hidden = hide_cnt_reg != '0;

    // Last wake cause latched for software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_reg <= '0;
        end else if (state_reg != lpwc_pkg::ST_ACTIVE
                     && state_next == lpwc_pkg::ST_ACTIVE) begin
            cause_reg <= {evt[lpwc_pkg::SRC_RST_PIN],
                          evt[NW-1:0] & en_reg};
        end
    end

    // Hint window after a pin wake so the pending reset can land
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_cnt_reg <= '0;
        end else if (state_reg != lpwc_pkg::ST_ACTIVE
                     && evt[lpwc_pkg::SRC_RST_PIN]) begin
            keep_cnt_reg <=
                lpwc_pkg::KEEP_W'(lpwc_pkg::KEEP_AWAKE_CLKS);
        end else if (keep_cnt_reg != '0) begin
            keep_cnt_reg <= keep_cnt_reg - 1'b1;
        end
    end

    // Supply monitor control; a reset with it off forces full POR
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_dis_reg  <= 1'b0;
            full_por_reg <= 1'b0;
        end else begin
            full_por_reg <= evt[lpwc_pkg::SRC_RST_REQ] & mon_dis_reg;
            if (evt[lpwc_pkg::SRC_RST_REQ]) begin
                mon_dis_reg <= 1'b0;
            end else if (wr_mode) begin
                mon_dis_reg <= pwdata[lpwc_pkg::MODE_MON_DIS_BIT];
            end
        end
    end

    // Low-power oscillator off request, refused while flags pend
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_osc_off_reg <= 1'b0;
        end else if (wr_mode) begin
            lp_osc_off_reg <= pwdata[lpwc_pkg::MODE_OSC_OFF_BIT]
                            & ~refuse;
        end
    end

    // Location zero may be overwritten on the way out of sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xram_reg <= 1'b0;
        end else begin
            xram_reg <= state_reg == lpwc_pkg::ST_SLEEP
                      && state_next == lpwc_pkg::ST_ACTIVE;
        end
    end

    // Read images; write-only mode selects read as zero
    assign cfg_rd = {3'b000,
                     pin_flag_reg & ~hidden,
                     flags_reg[lpwc_pkg::CFG_SRC_MSB:0]
                     & {4{~hidden}}};
    assign flg_rd = {7'b000_0000,
                     flags_reg[lpwc_pkg::SRC_CAP] & ~hidden};

    // APB slave: one wait-free access phase, error on unmapped word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup
                & !(addr_hit(paddr, lpwc_pkg::CONFIG_IDX)
                  | addr_hit(paddr, lpwc_pkg::FLAGS_IDX)
                  | addr_hit(paddr, lpwc_pkg::MODE_IDX)
                  | addr_hit(paddr, lpwc_pkg::STATUS_IDX));
            prdata_reg  <= '0;
            if (setup && !pwrite) begin
                if (addr_hit(paddr, lpwc_pkg::CONFIG_IDX)) begin
                    prdata_reg <= {24'h00_0000, cfg_rd};
                end else if (addr_hit(paddr, lpwc_pkg::FLAGS_IDX)) begin
                    prdata_reg <= {24'h00_0000, flg_rd};
                end else if (addr_hit(paddr, lpwc_pkg::MODE_IDX)) begin
                    prdata_reg[lpwc_pkg::MODE_MON_DIS_BIT] <= mon_dis_reg;
                    prdata_reg[lpwc_pkg::MODE_OSC_OFF_BIT] <= lp_osc_off_reg;
                end else if (addr_hit(paddr, lpwc_pkg::STATUS_IDX)) begin
                    prdata_reg[1:0] <= state_reg;
                    prdata_reg[lpwc_pkg::STAT_KEEP_BIT] <= keep_cnt_reg != '0;
                    prdata_reg[lpwc_pkg::STAT_CAUSE_LSB +: 6] <= cause_reg;
                end
            end
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign sleep_active       = sleep_reg;
    assign suspend_active     = suspend_reg;
    assign sysclk_gate        = gate_reg;
    assign osc_all_off        = osc_all_off_reg;
    assign ram_retain         = retain_reg;
    assign lp_osc_off         = lp_osc_off_reg;
    assign supply_monitor_off = mon_dis_reg;
    assign full_por_req       = full_por_reg;
    assign xram_zero_strobe   = xram_reg;

    // Checks beside the logic
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_left_suspend;
        state_reg == lpwc_pkg::ST_SUSPEND ##1 state_reg == lpwc_pkg::ST_ACTIVE;
    endsequence

    sequence s_sleep_req;
        state_reg == lpwc_pkg::ST_ACTIVE && wr_cfg
        && pwdata[lpwc_pkg::CFG_SLEEP_BIT];
    endsequence

    property p_pin_wake;
        state_reg == lpwc_pkg::ST_SLEEP && evt[lpwc_pkg::SRC_RST_PIN]
        |=> state_reg == lpwc_pkg::ST_ACTIVE ##1 !sleep_active;
    endproperty
    a_pin_wake: assert property (p_pin_wake)
        else $error("pin falling edge did not wake from sleep");

    property p_sleep_wake;
        state_reg == lpwc_pkg::ST_SLEEP && |(evt[3:0] & en_reg[3:0])
        |=> state_reg == lpwc_pkg::ST_ACTIVE;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("enabled source did not end sleep");

    property p_cap_suspend;
        state_reg == lpwc_pkg::ST_SUSPEND && evt[lpwc_pkg::SRC_CAP]
        && en_reg[lpwc_pkg::SRC_CAP] |=> !suspend_active;
    endproperty
    a_cap_suspend: assert property (p_cap_suspend)
        else $error("cap-sense event did not end suspend");

    property p_refuse;
        s_sleep_req and (|(flags_reg & en_next) && !clear_w)
        |=> state_reg == lpwc_pkg::ST_ACTIVE && !sleep_active;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("sleep entered with enabled flag set");

    property p_enter_sleep;
        s_sleep_req and !refuse |=> sleep_active && ram_retain && sysclk_gate;
    endproperty
    a_enter_sleep: assert property (p_enter_sleep)
        else $error("accepted sleep write did not retain and gate");

    property p_hide;
        s_left_suspend |-> (cfg_rd[4:0] == 5'h00 && flg_rd == 8'h00)[*2]
                           ##1 !hidden;
    endproperty
    a_hide: assert property (p_hide)
        else $error("flags not hidden for two clocks after suspend");

    property p_flag_set;
        evt[0] |=> flags_reg[0];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("comparator event did not set its flag");

    property p_sticky;
        !clear_w |=> (flags_reg & $past(flags_reg)) == $past(flags_reg);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("wake flag dropped without clear");

    property p_clear;
        clear_w && evt == '0 |=> flags_reg == '0 && !pin_flag_reg;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear command left a flag set");

    property p_por;
        evt[lpwc_pkg::SRC_RST_REQ] && mon_dis_reg
        |=> full_por_req && !supply_monitor_off;
    endproperty
    a_por: assert property (p_por)
        else $error("reset with monitor off gave no full POR");

endmodule : lpwc_top

`default_nettype wire

// ---- core/lpwc_pkg.sv ----
package lpwc_pkg;

    // APB address width and register indices (byte address = index * 4)
    localparam int          ADDR_W      = 12;
    localparam logic [7:0]  CONFIG_IDX  = 8'hb5;
    localparam logic [7:0]  FLAGS_IDX   = 8'hce;
    localparam logic [7:0]  MODE_IDX    = 8'hb6;
    localparam logic [7:0]  STATUS_IDX  = 8'hb7;

    // Configuration register fields
    localparam int CFG_SLEEP_BIT    = 7;
    localparam int CFG_SUSPEND_BIT  = 6;
    localparam int CFG_CLEAR_BIT    = 5;
    localparam int CFG_PIN_FLAG_BIT = 4;
    localparam int CFG_SRC_MSB      = 3;

    // Flag register, mode register and status register fields
    localparam int FLG_CAP_BIT      = 0;
    localparam int MODE_MON_DIS_BIT = 5;
    localparam int MODE_OSC_OFF_BIT = 0;
    localparam int STAT_KEEP_BIT    = 2;
    localparam int STAT_CAUSE_LSB   = 3;

    // Wake source vector: 3 osc fail, 2 alarm, 1 port match, 0 comparator
    localparam int NUM_WAKE     = 5;
    localparam int NUM_IN       = 7;
    localparam int SRC_CAP      = 4;
    localparam int SRC_RST_PIN  = 5;
    localparam int SRC_RST_REQ  = 6;
    localparam logic [NUM_IN-1:0]   FALL_MASK    = 7'h20;
    localparam logic [NUM_WAKE-1:0] SLEEP_MASK   = 5'h0f;
    localparam logic [NUM_WAKE-1:0] SUSPEND_MASK = 5'h1f;

    // Timing
    localparam int CLK_MHZ         = 50;
    localparam int KEEP_AWAKE_US   = 15;
    localparam int KEEP_AWAKE_CLKS = KEEP_AWAKE_US * CLK_MHZ;
    localparam int KEEP_W          = 10;
    localparam int FLAG_HIDE_CLKS  = 2;

    typedef enum logic [1:0] {
        ST_ACTIVE  = 2'b00,
        ST_SLEEP   = 2'b01,
        ST_SUSPEND = 2'b10
    } lpwc_state_t;

endpackage : lpwc_pkg

// ---- core/lpwc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for asynchronous pins
module lpwc_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule : lpwc_sync

`default_nettype wire

// ---- core/lpwc_edge.sv ----
`timescale 1ns/1ps
`default_nettype none

// Per-bit edge detector; a set mask bit selects falling edges
module lpwc_edge #(
    parameter int               WIDTH     = 7,
    parameter logic [WIDTH-1:0] FALL_MASK = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] pulse
);
    logic [WIDTH-1:0] prev_reg;

    // Previous sample; reset low so no fake falling edge at start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_edge
            assign pulse[i] = FALL_MASK[i] ? (prev_reg[i] & ~level[i])
                                           : (level[i] & ~prev_reg[i]);
        end
    endgenerate

endmodule : lpwc_edge

`default_nettype wire

// ---- verification/tb_low_power_wakeup_controller.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_low_power_wakeup_controller;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  ev;
    logic        pin_n, rst_req, err;
    logic        sleep_active, suspend_active, sysclk_gate, osc_all_off;
    logic        ram_retain, lp_osc_off, supply_monitor_off;
    logic        full_por_req, xram_zero_strobe, por_seen;
    int          n_fail, check_count, i;
    // Expected reads per event: comp, port, alarm, osc fail, cap sense
    localparam logic [7:0] CFG_EXP [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00};
    localparam logic [7:0] FLG_EXP [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};

    lpwc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator_out(ev[0]), .port_match_evt(ev[1]),
        .rtc_alarm_evt(ev[2]), .rtc_osc_fail(ev[3]),
        .cap_sense_done(ev[4]), .reset_pin_n(pin_n),
        .reset_request(rst_req), .sleep_active(sleep_active),
        .suspend_active(suspend_active), .sysclk_gate(sysclk_gate),
        .osc_all_off(osc_all_off), .ram_retain(ram_retain),
        .lp_osc_off(lp_osc_off), .supply_monitor_off(supply_monitor_off),
        .full_por_req(full_por_req), .xram_zero_strobe(xram_zero_strobe));

    // Free-running 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Sticky record of the one-cycle full-reset pulse, too short to poll
    always @(posedge pclk) por_seen <= presetn & (por_seen | full_por_req);

    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; idle edge first so psel never toggles twice a step
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin n_fail++; test_done(); end
    endtask : apb

    // Bounded wait for the block to leave sleep or suspend
    task wait_awake;
        int k;
        k = 0;
        while ((sleep_active | suspend_active) !== 1'b0 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 50) begin n_fail++; test_done(); end
    endtask : wait_awake

    // Hold an event pin high long enough to pass the synchroniser
    task pulse(input int n);
        ev[n] <= 1'b1;
        repeat (5) @(posedge pclk);
        ev[n] <= 1'b0;
    endtask : pulse

    // Main sequence: table of events, then hand-written corner cases
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; ev = 5'h00;
        pin_n = 1'b1; rst_req = 1'b0; n_fail = 0; check_count = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, lpwc_pkg::CONFIG_IDX, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        for (i = 0; i < 5; i++) begin
            pulse(i);
            apb(1'b0, lpwc_pkg::CONFIG_IDX, 32'h0000_0000);
            chk(rd, {24'h00_0000, CFG_EXP[i]});
            apb(1'b0, lpwc_pkg::FLAGS_IDX, 32'h0000_0000);
            chk(rd, {24'h00_0000, FLG_EXP[i]});
            apb(1'b1, lpwc_pkg::CONFIG_IDX, 32'h0000_0020);
            apb(1'b0, lpwc_pkg::FLAGS_IDX, 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        apb(1'b1, lpwc_pkg::FLAGS_IDX, 32'h0000_00fe);
        apb(1'b0, lpwc_pkg::FLAGS_IDX, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // Sleep with comparator enabled, then a comparator edge wakes it
        apb(1'b1, lpwc_pkg::CONFIG_IDX, 32'h0000_0081);
        repeat (2) @(posedge pclk);
        chk({29'h0000_0000, sleep_active, ram_retain, sysclk_gate},
            32'h0000_0007);
        pulse(0);
        wait_awake();
        // Flag still set and enabled: entry and osc-off are refused
        apb(1'b1, lpwc_pkg::CONFIG_IDX, 32'h0000_0081);
        apb(1'b1, lpwc_pkg::MODE_IDX, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk({30'h0000_0000, sleep_active, lp_osc_off}, 32'h0000_0000);
        // Once flags are clear the same oscillator request is accepted
        apb(1'b1, lpwc_pkg::CONFIG_IDX, 32'h0000_0020);
        apb(1'b1, lpwc_pkg::MODE_IDX, 32'h0000_0001);
        @(posedge pclk);
        chk({31'h0000_0000, lp_osc_off}, 32'h0000_0001);
        // Disabled source must not wake; the reset pin always does
        apb(1'b1, lpwc_pkg::CONFIG_IDX, 32'h0000_0080);
        pulse(1);
        repeat (3) @(posedge pclk);
        chk({31'h0000_0000, sleep_active}, 32'h0000_0001);
        pin_n <= 1'b0;
        wait_awake();
        chk({31'h0000_0000, xram_zero_strobe}, 32'h0000_0001);
        pin_n <= 1'b1;
        apb(1'b0, lpwc_pkg::CONFIG_IDX, 32'h0000_0000);
        chk(rd, 32'h0000_0012);
        apb(1'b0, lpwc_pkg::STATUS_IDX, 32'h0000_0000);
        chk(rd, 32'h0000_0104);
        // Stay awake through the pin-reset window before suspending
        repeat (lpwc_pkg::KEEP_AWAKE_CLKS) @(posedge pclk);
        apb(1'b0, lpwc_pkg::STATUS_IDX, 32'h0000_0000);
        chk(rd, 32'h0000_0100);
        apb(1'b1, lpwc_pkg::CONFIG_IDX, 32'h0000_0020);
        // Suspend stops the oscillators; a cap-sense event brings it back
        apb(1'b1, lpwc_pkg::FLAGS_IDX, 32'h0000_0001);
        apb(1'b1, lpwc_pkg::CONFIG_IDX, 32'h0000_0040);
        repeat (2) @(posedge pclk);
        chk({30'h0000_0000, suspend_active, osc_all_off},
            32'h0000_0003);
        pulse(4);
        wait_awake();
        apb(1'b0, lpwc_pkg::FLAGS_IDX, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        // Reset source with monitor off re-enables the monitor
        apb(1'b1, lpwc_pkg::MODE_IDX, 32'h0000_0020);
        repeat (2) @(posedge pclk);
        chk({30'h0000_0000, por_seen, supply_monitor_off},
            32'h0000_0001);
        rst_req <= 1'b1;
        repeat (8) @(posedge pclk);
        chk({30'h0000_0000, por_seen, supply_monitor_off},
            32'h0000_0002);
        test_done();
    end
endmodule : tb_low_power_wakeup_controller

`default_nettype wire
